// ===== shared/dd_encoder_regs.svh
// constants of the double density record encoder
// Functional notes
// - record indication picks record or playback
// - recording passes only bit clock and data
// - playback uses external or internal 10MHz clock
// - clock select ignored while recording
// - polarity setting inverts incoming biphase data
// - bit clock divided by 50 drives servo
// - bit clock divided by 12 gives word strobe
// - word strobe divided by 128 feeds reference
// - system bit clock over 16 gives track rate
// - track rate over 8 then 17 is feedback
// - track rate is 17/16 of word rate
// - 16x12 buffer from three 4x16 memories
// - after 128 bits suppress output 8 bits
// - buffer writing continues during suppression
// - sync toggle makes pattern 4,3,4,3
// - eight padding bits: 136 bits per 128
// - per track transition code mixed with sync
// - toggle flop halves into double density
// - intervals 2,3,4 are 1,1.5,2 bits
// - data never odd 3s between 4s
// - twelve tracks each get own output
`ifndef DD_ENCODER_REGS_SVH
`define DD_ENCODER_REGS_SVH
`define CTRL_OFS 8'h00
`define STATUS_OFS 8'h04
`define CTRL_RESET 32'h0000_0000
`define CTRL_CLKSEL_BIT 0
`define CTRL_POL_BIT 1
`define STAT_REC_BIT 0
`define STAT_WR_LSB 4
`define STAT_RD_LSB 8
`define CLK_HZ 40000000
`define INT_CLK_HZ 10000000
`define INT_DIV (`CLK_HZ / `INT_CLK_HZ)
`define SERVO_HALF 25
`define WORD_BITS 12
`define FRAME_WORDS 128
`define FB_DIV_A 8
`define FB_DIV_B 17
`define HALF_PER_STROBE 34
`define HALF_PER_BIT_DEN 16
`define DATA_HALVES 256
`define FRAME_HALVES 272
`define SYNC_MASK 16'h4891
`endif

// ===== shared/dd_encoder_pkg.sv
// types shared by the double density record encoder
package dd_encoder_pkg;
  typedef struct packed {
    logic rec_ind;
    logic ext_clk;
    logic data;
    logic bit_clk;
  } pins_s;
  typedef logic [11:0] track_word_t;
  typedef enum logic [1:0] {
    MODE_PLAY = 2'b01,
    MODE_REC = 2'b10
  } mode_e;
endpackage : dd_encoder_pkg

// ===== rtl/dd_record_encoder.sv
// double density twelve-track record encoder with axi4-lite control
`timescale 1ns/1ps
`default_nettype none
`include "dd_encoder_regs.svh"
module dd_record_encoder
  import dd_encoder_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic bit_clk_in,
  input wire logic bilevel_data_in,
  input wire logic ext_clk_in,
  input wire logic record_indicate_in,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic servo_ref,
  output logic word_enable_strobe,
  output logic phase_ref,
  output logic feedback_ref,
  output logic sync_toggle_signal,
  output track_word_t track_out
);
  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers: a change counts once stages two and three agree
  pins_s pins_in;
  pins_s s1_ff, s2_ff, s3_ff, filt_ff, filt_d_ff, nxt_filt;
  assign pins_in = '{rec_ind: record_indicate_in, ext_clk: ext_clk_in,
                     data: bilevel_data_in, bit_clk: bit_clk_in};
  assign nxt_filt = (s3_ff & ~(s2_ff ^ s3_ff)) | (filt_ff & (s2_ff ^ s3_ff));
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
      filt_ff <= '0;
      filt_d_ff <= '0;
    end else begin
      s1_ff <= pins_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      filt_ff <= nxt_filt;
      filt_d_ff <= filt_ff;
    end
  end
  wire bit_rise = filt_ff.bit_clk & ~filt_d_ff.bit_clk;
  wire ext_rise = filt_ff.ext_clk & ~filt_d_ff.ext_clk;

  ////////////////////////////////////////////////////////////////////////
  // control registers over axi4-lite
  logic [31:0] ctrl_ff;
  logic aw_got_ff, w_got_ff;
  logic [7:0] awaddr_ff;
  logic [31:0] wdata_ff;
  logic [3:0] wstrb_ff;
  logic bvalid_ff, rvalid_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic [31:0] rdata_ff;
  logic [3:0] wr_addr_ff, rd_addr_ff;
  mode_e mode_ff;
  wire aw_take = s_axi_awvalid & ~aw_got_ff & ~bvalid_ff;
  wire w_take = s_axi_wvalid & ~w_got_ff & ~bvalid_ff;
  wire wr_go = aw_got_ff & w_got_ff & ~bvalid_ff;
  wire wr_ctrl = wr_go & (awaddr_ff == `CTRL_OFS);
  wire wr_hit = wr_ctrl | (awaddr_ff == `STATUS_OFS);
  wire ar_take = s_axi_arvalid & ~rvalid_ff;
  wire [31:0] byte_mask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                           {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};
  wire [31:0] nxt_ctrl = (ctrl_ff & ~byte_mask) | (wdata_ff & byte_mask);
  wire [31:0] status_word = {20'h0_0000, rd_addr_ff, wr_addr_ff, 3'h0,
                             mode_ff == MODE_REC};
  wire ar_ctrl = s_axi_araddr == `CTRL_OFS;
  wire ar_stat = s_axi_araddr == `STATUS_OFS;
  wire [31:0] rd_mux = ar_ctrl ? ctrl_ff : (ar_stat ? status_word : 32'h0);
  wire clk_sel = ctrl_ff[`CTRL_CLKSEL_BIT];
  wire pol = ctrl_ff[`CTRL_POL_BIT];
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_ff <= `CTRL_RESET;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0000_0000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
    end else begin
      if (aw_take) begin
        aw_got_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (w_take) begin
        w_got_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_ctrl) begin
        ctrl_ff <= nxt_ctrl;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_hit ? 2'h0 : 2'h3;
        aw_got_ff <= 1'b0;
        w_got_ff <= 1'b0;
      end else if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= 2'h0;
    end else if (ar_take) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= rd_mux;
      rresp_ff <= (ar_ctrl | ar_stat) ? 2'h0 : 2'h3;
    end else if (rvalid_ff && s_axi_rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign s_axi_awready = aw_take;
  assign s_axi_wready = w_take;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = ar_take;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  ////////////////////////////////////////////////////////////////////////
  // mode, clock and data selection
  logic [1:0] int_cnt_ff;
  wire int_tick = int_cnt_ff == 2'(`INT_DIV - 1);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      mode_ff <= MODE_PLAY;
      int_cnt_ff <= 2'h0;
    end else begin
      int_cnt_ff <= int_tick ? 2'h0 : int_cnt_ff + 2'h1;
      case (mode_ff)
        MODE_PLAY: if (filt_ff.rec_ind) mode_ff <= MODE_REC;
        MODE_REC: if (!filt_ff.rec_ind) mode_ff <= MODE_PLAY;
        default: mode_ff <= MODE_PLAY;
      endcase
    end
  end
  wire rec = mode_ff == MODE_REC;
  wire play_tick = clk_sel ? ext_rise : int_tick;
  wire sel_tick = rec ? bit_rise : play_tick;
  // bi-level data is sampled in its first half, which carries the nrzl level
  wire nrzl_bit = rec & (filt_ff.data ^ pol);

  ////////////////////////////////////////////////////////////////////////
  // dividers: servo /50, word strobe /12, frame /128
  logic [4:0] servo_cnt_ff;
  logic [3:0] bit_cnt_ff;
  logic [6:0] word_cnt_ff;
  logic [10:0] sp_ff;
  logic servo_ff, strobe_ff, phase_ff;
  wire strobe_now = sel_tick & (bit_cnt_ff == 4'(`WORD_BITS - 1));
  wire servo_wrap = servo_cnt_ff == 5'(`SERVO_HALF - 1);
  wire track_word_t in_word = {sp_ff, nrzl_bit};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      servo_cnt_ff <= 5'h00;
      bit_cnt_ff <= 4'h0;
      word_cnt_ff <= 7'h00;
      sp_ff <= 11'h000;
      servo_ff <= 1'b0;
      strobe_ff <= 1'b0;
      phase_ff <= 1'b0;
    end else begin
      strobe_ff <= strobe_now;
      phase_ff <= word_cnt_ff[6];
      if (sel_tick) begin
        sp_ff <= in_word[10:0];
        servo_cnt_ff <= servo_wrap ? 5'h00 : servo_cnt_ff + 5'h01;
        if (servo_wrap) servo_ff <= ~servo_ff;
        bit_cnt_ff <= strobe_now ? 4'h0 : bit_cnt_ff + 4'h1;
      end
      if (strobe_now) word_cnt_ff <= word_cnt_ff + 7'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // encoder buffer: three 4-bit slices of 16 words
  track_word_t rd_word;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_slice
      logic [3:0] mem_ff [16];
      // cleared at reset: reads start before the first word lands, and an
      // unknown word would poison the track toggles for good
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          for (int i = 0; i < 16; i++) mem_ff[i] <= 4'h0;
        end else if (strobe_now) begin
          // writes go on at the input rate even in the sync gap
          mem_ff[wr_addr_ff] <= in_word[4*g +: 4];
        end
      end
      assign rd_word[4*g +: 4] = mem_ff[rd_addr_ff];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // track rate: 34 half-bit credits per word strobe, 16 per half-bit tick
  logic [5:0] credit_ff;
  logic [8:0] half_cnt_ff;
  logic [2:0] fb_a_ff;
  logic [4:0] fb_b_ff;
  logic fb_ff;
  wire half_tick = credit_ff >= 6'(`HALF_PER_BIT_DEN);
  wire [5:0] credit_add = strobe_now ? 6'(`HALF_PER_STROBE) : 6'h00;
  wire [5:0] credit_sub = half_tick ? 6'(`HALF_PER_BIT_DEN) : 6'h00;
  wire half_wrap = half_cnt_ff == 9'(`FRAME_HALVES - 1);
  wire data_slot = half_cnt_ff < 9'(`DATA_HALVES);
  wire bit_end = half_tick & half_cnt_ff[0];
  wire fb_a_wrap = fb_a_ff == 3'(`FB_DIV_A - 1);
  wire fb_b_wrap = fb_b_ff == 5'(`FB_DIV_B - 1);
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      credit_ff <= 6'h00;
      half_cnt_ff <= 9'h000;
      fb_a_ff <= 3'h0;
      fb_b_ff <= 5'h00;
      fb_ff <= 1'b0;
      wr_addr_ff <= 4'h0;
      rd_addr_ff <= 4'h0;
    end else begin
      credit_ff <= credit_ff + credit_add - credit_sub;
      if (half_tick) begin
        half_cnt_ff <= half_wrap ? 9'h000 : half_cnt_ff + 9'h001;
      end
      if (bit_end) begin
        fb_a_ff <= fb_a_wrap ? 3'h0 : fb_a_ff + 3'h1;
        if (fb_a_wrap) begin
          fb_b_ff <= fb_b_wrap ? 5'h00 : fb_b_ff + 5'h01;
        end
      end
      fb_ff <= fb_b_ff < 5'h09;
      if (strobe_now) wr_addr_ff <= wr_addr_ff + 4'h1;
      // read address holds through the sync gap
      if (bit_end && data_slot) rd_addr_ff <= rd_addr_ff + 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-track transition code, sync mix and divide-by-two
  track_word_t cur_ff, prev_ff, dd_ff, data_trans, trans;
  logic sync_ff;
  wire [15:0] sync_mask = `SYNC_MASK;
  wire sync_hit = sync_mask[half_cnt_ff[3:0]];
  // a 1 moves mid-bit, a 0 after a 0 moves at the cell edge; this keeps
  // intervals at 2, 3 and 4 half-bit units and odd 3-runs out of data
  assign data_trans = half_cnt_ff[0] ? cur_ff
                                     : (~rd_word & ~prev_ff);
  assign trans = data_slot ? data_trans : {12{sync_hit}};
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cur_ff <= 12'h000;
      prev_ff <= 12'h000;
      dd_ff <= 12'h000;
      sync_ff <= 1'b0;
    end else begin
      sync_ff <= half_tick & ~data_slot & sync_hit;
      if (half_tick) begin
        dd_ff <= dd_ff ^ trans;
        if (data_slot && !half_cnt_ff[0]) cur_ff <= rd_word;
        if (data_slot && half_cnt_ff[0]) prev_ff <= cur_ff;
        // after sync, a leading 0 must not add an edge at the padding end
        if (!data_slot) prev_ff <= 12'hfff;
      end
    end
  end
  assign servo_ref = servo_ff;
  assign word_enable_strobe = strobe_ff;
  assign phase_ref = phase_ff;
  assign feedback_ref = fb_ff;
  assign sync_toggle_signal = sync_ff;
  assign track_out = dd_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_mode_follow: assert property (@(posedge clk) disable iff (!resetn)
    filt_ff.rec_ind |=> mode_ff == MODE_REC)
    else $error("mode did not follow record indication");
  a_play_no_data: assert property (@(posedge clk) disable iff (!resetn)
    sel_tick && !rec |=> sp_ff[0] == 1'b0)
    else $error("data passed while playing back");
  a_int_clock: assert property (@(posedge clk) disable iff (!resetn)
    !rec && !clk_sel && int_tick |-> sel_tick)
    else $error("internal clock not used in playback");
  a_rec_clock: assert property (@(posedge clk) disable iff (!resetn)
    rec && !bit_rise |-> !sel_tick)
    else $error("non bit clock used while recording");
  a_polarity_inv: assert property (@(posedge clk) disable iff (!resetn)
    rec && bit_rise |=> sp_ff[0] == $past(filt_ff.data ^ pol))
    else $error("polarity not applied");
  a_servo_div: assert property (@(posedge clk) disable iff (!resetn)
    $changed(servo_ff) |-> $past(sel_tick) && $past(servo_cnt_ff) == 24)
    else $error("servo toggled off count");
  a_strobe_div: assert property (@(posedge clk) disable iff (!resetn)
    strobe_ff |-> $past(bit_cnt_ff) == 4'hb && $past(sel_tick))
    else $error("word strobe off count");
  a_sync_gap: assert property (@(posedge clk) disable iff (!resetn)
    !data_slot |=> $stable(rd_addr_ff))
    else $error("buffer read during sync");
  a_sync_pattern: assert property (@(posedge clk) disable iff (!resetn)
    sync_ff |-> $past(half_cnt_ff[3:0]) inside {0, 4, 7, 11, 14})
    else $error("sync edge outside pattern");
  a_dd_toggle: assert property (@(posedge clk) disable iff (!resetn)
    half_tick |=> dd_ff == ($past(dd_ff) ^ $past(trans)))
    else $error("track waveform missed a toggle");
endmodule : dd_record_encoder
`default_nettype wire

// ===== verif/serial_source.sv
// behavioural far-side source: pin clock and biphase-level data
`timescale 1ns/1ps
`default_nettype none
module serial_source #(
  parameter int HALF = 8
) (
  input wire logic clk,
  input wire logic run,
  input wire logic [15:0] pattern,
  output logic pin_clk,
  output logic pin_data
);
  int ph;
  int idx;
  initial begin
    ph = 0;
    idx = 0;
    pin_clk = 1'b0;
    pin_data = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // clock stands still outside a run; idle data toggles so no stale level
  always @(posedge clk) begin
    if (!run) begin
      ph <= 0;
      pin_clk <= 1'b0;
      pin_data <= ~pin_data;
    end else begin
      ph <= (ph == 2 * HALF - 1) ? 0 : ph + 1;
      idx <= (ph == 2 * HALF - 1) ? (idx + 1) % 16 : idx;
      pin_clk <= (ph < HALF);
      pin_data <= pattern[idx] ^ (ph >= HALF);
    end
  end
endmodule : serial_source
`default_nettype wire

// ===== verif/double_density_record_encoder_bench.sv
// self-checking bench of the double density record encoder
`timescale 1ns/1ps
`default_nettype none
`include "dd_encoder_regs.svh"
`define CHK(nm, ex, got) begin total_checks++; if ((got) !== (ex)) begin \
  n_mismatch++; $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); \
  end end
module double_density_record_encoder_bench
  import dd_encoder_pkg::*;
;
  logic clk = 1'b0, resetn = 1'b0, rec_ind = 1'b0, src_run = 1'b0;
  logic ext_run = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, d, a;
  logic [1:0] bresp, rresp, r;
  logic awready, wready, bvalid, arready, rvalid, src_clk, src_data, ext_clk;
  logic servo, strobe, phase, fb, sync;
  logic [3:0] mon;
  track_word_t track;
  int n_mismatch = 0, total_checks = 0, p, ns, nf;
  assign mon = {fb, phase, servo, strobe};
  serial_source #(.HALF(8)) u_src (.clk(clk), .run(src_run),
    .pattern(16'hc3a5), .pin_clk(src_clk), .pin_data(src_data));
  serial_source #(.HALF(6)) u_ext (.clk(clk), .run(ext_run),
    .pattern(16'h0000), .pin_clk(ext_clk), .pin_data());
  dd_record_encoder dut (
    .clk(clk),
    .resetn(resetn),
    .bit_clk_in(src_clk),
    .bilevel_data_in(src_data),
    .ext_clk_in(ext_clk),
    .record_indicate_in(rec_ind),
    .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid),
    .s_axi_awready(awready),
    .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid),
    .s_axi_wready(wready),
    .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid),
    .s_axi_bready(bready),
    .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid),
    .s_axi_arready(arready),
    .s_axi_rdata(rdata),
    .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid),
    .s_axi_rready(rready),
    .servo_ref(servo),
    .word_enable_strobe(strobe),
    .phase_ref(phase),
    .feedback_ref(fb),
    .sync_toggle_signal(sync),
    .track_out(track)
  );
  initial begin
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  // handshakes sampled on the falling edge, acted on at the next rise
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] dt,
                        output logic [1:0] rs);
    logic ta, tw, bv;
    @(posedge clk);
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    bv = 1'b0;
    while (bv !== 1'b1) begin
      @(negedge clk);
      ta = awvalid & awready;
      tw = wvalid & wready;
      bv = bvalid;
      rs = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] ad, output logic [31:0] dt,
                        output logic [1:0] rs);
    logic ta, rv;
    @(posedge clk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    rv = 1'b0;
    while (rv !== 1'b1) begin
      @(negedge clk);
      ta = arvalid & arready;
      rv = rvalid;
      dt = rdata;
      rs = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'b0;
    end
    rready <= 1'b0;
  endtask : axi_rd
  // cycles from the previous rise of a monitored output to its next rise
  task automatic wait_rise(input int sel, output int n);
    n = 0;
    do begin @(negedge clk); n++; end while (mon[sel] !== 1'b0);
    do begin @(negedge clk); n++; end while (mon[sel] !== 1'b1);
  endtask : wait_rise
  task automatic count_win(input int len, output int s, output int f);
    logic fp;
    s = 0;
    f = 0;
    fp = fb;
    repeat (len) begin
      @(negedge clk);
      s += (sync === 1'b1);
      f += (fb === 1'b1 && fp === 1'b0);
      fp = fb;
    end
  endtask : count_win
  task automatic end_sim();
    if (n_mismatch == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_sim
  ////////////////////////////////////////////////////////////////////////
  // the span covers four reference periods plus margin for the slow pin
  initial begin
    repeat (80000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    repeat (19) @(posedge clk);
    `CHK("outputs in reset", 17'h0, {servo, strobe, phase, fb, sync, track})
    @(posedge clk);
    resetn <= 1'b1;
    axi_rd(`CTRL_OFS, d, r);
    `CHK("ctrl reset", 34'h0, {r, d})
    axi_rd(`STATUS_OFS, d, r);
    `CHK("status reset", 34'h0, {r, d})
    axi_rd(8'h40, d, r);
    `CHK("unmapped read", {2'b11, 32'h0}, {r, d})
    axi_wr(8'h40, 32'h3, r);
    `CHK("unmapped write", 2'b11, r)
    wait_rise(0, p);
    wait_rise(0, p);
    `CHK("strobe internal", `WORD_BITS * `INT_DIV, p)
    wait_rise(1, p);
    wait_rise(1, p);
    `CHK("servo internal", 2 * `SERVO_HALF * `INT_DIV, p)
    axi_rd(`STATUS_OFS, a, r);
    wait_rise(0, p);
    axi_rd(`STATUS_OFS, d, r);
    `CHK("write address step", a[7:4] + 4'h1, d[7:4])
    wait_rise(2, p);
    wait_rise(2, p);
    `CHK("phase ref", `FRAME_WORDS * `WORD_BITS * `INT_DIV, p)
    // two frames counted; pulse jitter of the rate credit allows one off
    count_win(2 * p, ns, nf);
    `CHK("sync edges", 1'b1, (ns >= 9 && ns <= 11))
    `CHK("feedback rises", 1'b1, (nf >= 1 && nf <= 3))
    ext_run <= 1'b1;
    axi_wr(`CTRL_OFS, 32'h1, r);
    `CHK("ctrl write", 2'b00, r)
    wait_rise(0, p);
    wait_rise(0, p);
    `CHK("strobe external", `WORD_BITS * 12, p)
    rec_ind <= 1'b1;
    src_run <= 1'b1;
    repeat (10) @(posedge clk);
    axi_rd(`STATUS_OFS, d, r);
    `CHK("record flag", 1'b1, d[`STAT_REC_BIT])
    wait_rise(0, p);
    wait_rise(0, p);
    `CHK("strobe record sel1", `WORD_BITS * 16, p)
    axi_wr(`CTRL_OFS, 32'h2, r);
    wait_rise(0, p);
    wait_rise(0, p);
    `CHK("strobe record sel0", `WORD_BITS * 16, p)
    `CHK("track known", 1'b0, $isunknown(track))
    wait_rise(1, p);
    wait_rise(1, p);
    `CHK("servo record", 2 * `SERVO_HALF * 16, p)
    axi_rd(`CTRL_OFS, d, r);
    `CHK("polarity setting", 32'h2, d)
    end_sim();
  end
endmodule : double_density_record_encoder_bench
`default_nettype wire
